// File: hw/ebrrt_pkg.sv
// Overview of operation
// R1 - unwaited read strobe low one clock
// R2 - address one clock before, held after
// R3 - memory data valid before strobe rises
// R4 - grant returns within 1.2 us
// R5 - legality flag within 3 us
// R6 - flag only for legal commands
// R7 - status response 0.4 to 0.8 us
// R8 - rt-to-rt receive 71 us timeout
// R9 - decode echo, verify transmitted word
// R10 - echo loop delay below 180 ns
// R11 - echo error sticky until cleared
// R12 - encoder clock accurate to 0.01%
// R13 - each sampled wait adds one clock
package ebrrt_pkg;
  localparam int CLK_MHZ = 50;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CMD_W = 12;
  localparam int SA_LSB = 5;
  localparam int SA_W = 5;
  localparam int RTADDR_W = 5;
  localparam int STAT_ERR_BIT = 10;
  // bus word: sync bits, 16 data bits, odd parity
  localparam int BIT_TIME_NS = 100;
  localparam int BIT_CYC = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam int SYNC_BITS = 3;
  localparam int FRAME_BITS = SYNC_BITS + DATA_W + 1;
  localparam logic [2:0] SYNC_PATTERN = 3'h7;
  // tx start to sync midpoint adds 1.5 bit times, giving 600 ns
  localparam int RESP_TIME_NS = 450;
  localparam int RESP_CYC = (RESP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RTRT_TIME_NS = 71000;
  localparam int RTRT_CYC = RTRT_TIME_NS * CLK_MHZ / 1000;
  localparam int LEGAL_TIME_NS = 3000;
  localparam int LEGAL_CYC = LEGAL_TIME_NS * CLK_MHZ / 1000;
  // stale flag from the previous command must drain through the synchroniser first
  localparam int LEGAL_SETTLE = SYNC_STAGES + 2;
  localparam int GRANT_TIME_NS = 1200;
  localparam int GRANT_CYC = GRANT_TIME_NS * CLK_MHZ / 1000;
  localparam int ECHO_TIME_NS = 180;
  localparam int ECHO_CYC = ECHO_TIME_NS * CLK_MHZ / 1000;
  localparam int SYNC_STAGES = 3;
  localparam int ECHO_WIN = ECHO_CYC + SYNC_STAGES + 2;
  localparam int CNT_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [CMD_W-1:0] CMD_RST = 12'h000;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b000,
    RD_REQ = 3'b001,
    RD_SETUP = 3'b010,
    RD_STROBE = 3'b011,
    RD_HOLD = 3'b100
  } ebrrt_rd_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SHIFT = 2'b10
  } ebrrt_tx_e;

  typedef enum logic [1:0] {
    EC_IDLE = 2'b00,
    EC_FIND = 2'b01,
    EC_BITS = 2'b10
  } ebrrt_ec_e;
endpackage : ebrrt_pkg

// File: hw/ebrrt_link_if.sv
`timescale 1ns/1ps
interface ebrrt_link_if;
  import ebrrt_pkg::*;
  logic backendRequestN;
  logic backendGrantN;
  logic backendReadStrobeN;
  logic [ADDR_W-1:0] backendAddr;
  logic [DATA_W-1:0] backendData;
  logic backendWait;
  logic [CMD_W-1:0] decodedCommandValue;
  logic commandLegalFlag;
  logic busATransmitOut;
  logic busAReceiveIn;

  modport dev (
    output backendRequestN, backendReadStrobeN, backendAddr, decodedCommandValue, busATransmitOut,
    input backendGrantN, backendData, backendWait, commandLegalFlag, busAReceiveIn
  );
  modport host (
    input backendRequestN, backendReadStrobeN, backendAddr, decodedCommandValue, busATransmitOut,
    output backendGrantN, backendData, backendWait, commandLegalFlag, busAReceiveIn
  );
endinterface : ebrrt_link_if

// File: hw/ebrrt_device.sv
`timescale 1ns/1ps
module ebrrt_device (
  input wire logic clk_sys,
  input wire logic rst,
  ebrrt_link_if.dev link,
  input wire logic readReq,
  input wire logic [ebrrt_pkg::ADDR_W-1:0] readAddr,
  output logic readBusy,
  output logic readDone,
  output logic readFail,
  output logic [ebrrt_pkg::DATA_W-1:0] readData,
  input wire logic cmdParityMid,
  input wire logic [ebrrt_pkg::CMD_W-1:0] cmdValue,
  input wire logic rtRtReceive,
  input wire logic firstDataSync,
  input wire logic [ebrrt_pkg::RTADDR_W-1:0] rtAddr,
  output logic cmdCheckDone,
  output logic cmdLegal,
  output logic rtRtActive,
  output logic rtRtTimeout,
  output logic echoCheckDone,
  output logic busAEchoError,
  input wire logic errorClearInput
);
  import ebrrt_pkg::*;

  // backend read sequencer
  ebrrt_rd_e rdState_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [CNT_W-1:0] grantCnt_r;
  logic done_r;
  logic fail_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdState_r <= RD_IDLE;
      grantCnt_r <= '0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      fail_r <= 1'b0;
      case (rdState_r)
        RD_IDLE: begin
          grantCnt_r <= '0;
          if (readReq) begin
            rdState_r <= RD_REQ;
          end
        end
        // R4 grant wait bound
        RD_REQ: begin
          grantCnt_r <= grantCnt_r + 1'b1;
          if (!link.backendGrantN) begin
            rdState_r <= RD_SETUP;
          end else if (grantCnt_r == CNT_W'(GRANT_CYC - 1)) begin
            fail_r <= 1'b1;
            rdState_r <= RD_IDLE;
          end
        end
        // R2 address setup cycle
        RD_SETUP: begin
          rdState_r <= RD_STROBE;
        end
        // R1 single strobe cycle
        // R13 wait extends strobe
        RD_STROBE: begin
          if (!link.backendWait) begin
            rdState_r <= RD_HOLD;
          end
        end
        RD_HOLD: begin
          done_r <= 1'b1;
          rdState_r <= RD_IDLE;
        end
        default: begin
          rdState_r <= RD_IDLE;
        end
      endcase
    end
  end

  // R2 address held through hold
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_r <= ADDR_RST;
    end else if (rdState_r == RD_IDLE && readReq) begin
      addr_r <= readAddr;
    end
  end

  // R3 capture at strobe end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_r <= DATA_RST;
    end else if (rdState_r == RD_STROBE && !link.backendWait) begin
      data_r <= link.backendData;
    end
  end

  assign link.backendRequestN = (rdState_r == RD_IDLE);
  assign link.backendReadStrobeN = (rdState_r != RD_STROBE);
  assign link.backendAddr = addr_r;
  assign readBusy = (rdState_r != RD_IDLE);
  assign readDone = done_r;
  assign readFail = fail_r;
  assign readData = data_r;

  // pin synchronisers: legality flag and echoed bus level
  logic [SYNC_STAGES-1:0] legSync_r;
  logic [SYNC_STAGES-1:0] rxSync_r;
  logic legLvl_r;
  logic rxLvl_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      legSync_r <= '0;
      rxSync_r <= '0;
      legLvl_r <= 1'b0;
      rxLvl_r <= 1'b0;
    end else begin
      legSync_r <= {legSync_r[SYNC_STAGES-2:0], link.commandLegalFlag};
      rxSync_r <= {rxSync_r[SYNC_STAGES-2:0], link.busAReceiveIn};
      if (legSync_r[1] == legSync_r[2]) begin
        legLvl_r <= legSync_r[2];
      end
      if (rxSync_r[1] == rxSync_r[2]) begin
        rxLvl_r <= rxSync_r[2];
      end
    end
  end

  // command legality check
  logic [CMD_W-1:0] decoded_command_value_r;
  logic [CNT_W-1:0] legCnt_r;
  logic legBusy_r;
  logic legal_r;
  logic legDone_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      decoded_command_value_r <= CMD_RST;
      legCnt_r <= '0;
      legBusy_r <= 1'b0;
      legal_r <= 1'b0;
      legDone_r <= 1'b0;
    end else begin
      legDone_r <= 1'b0;
      if (cmdParityMid) begin
        decoded_command_value_r <= cmdValue;
        legCnt_r <= '0;
        legBusy_r <= 1'b1;
        legal_r <= 1'b0;
      end else if (legBusy_r) begin
        // R5 legality deadline
        legCnt_r <= legCnt_r + 1'b1;
        if (legLvl_r && legCnt_r >= CNT_W'(LEGAL_SETTLE)) begin
          legal_r <= 1'b1;
          legBusy_r <= 1'b0;
          legDone_r <= 1'b1;
        end else if (legCnt_r == CNT_W'(LEGAL_CYC - 1)) begin
          legBusy_r <= 1'b0;
          legDone_r <= 1'b1;
        end
      end
    end
  end

  assign link.decodedCommandValue = decoded_command_value_r;
  assign cmdCheckDone = legDone_r;
  assign cmdLegal = legal_r;

  // rt-to-rt receive timeout
  logic [CNT_W-1:0] rtCnt_r;
  logic rtAct_r;
  logic rtTo_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rtCnt_r <= '0;
      rtAct_r <= 1'b0;
      rtTo_r <= 1'b0;
    end else begin
      rtTo_r <= 1'b0;
      if (cmdParityMid) begin
        rtCnt_r <= '0;
        rtAct_r <= rtRtReceive;
      end else if (rtAct_r) begin
        // R8 missing word times out
        rtCnt_r <= rtCnt_r + 1'b1;
        if (firstDataSync) begin
          rtAct_r <= 1'b0;
        end else if (rtCnt_r == CNT_W'(RTRT_CYC - 1)) begin
          rtAct_r <= 1'b0;
          rtTo_r <= 1'b1;
        end
      end
    end
  end

  assign rtRtActive = rtAct_r;
  assign rtRtTimeout = rtTo_r;

  // status word transmitter
  ebrrt_tx_e txState_r;
  logic [CNT_W-1:0] txCnt_r;
  logic [FRAME_BITS-1:0] txFrame_r;
  logic [FRAME_BITS-1:0] txShift_r;
  logic [7:0] txBits_r;
  logic bitTick;
  logic [DATA_W-1:0] statusWord;
  logic txStart;

  always_comb begin
    statusWord = '0;
    statusWord[DATA_W-1 -: RTADDR_W] = rtAddr;
    statusWord[STAT_ERR_BIT] = !legal_r;
  end

  assign bitTick = (txCnt_r == CNT_W'(BIT_CYC - 1));
  assign txStart = (txState_r == TX_WAIT) && (txCnt_r == CNT_W'(RESP_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txState_r <= TX_IDLE;
      txCnt_r <= '0;
      txFrame_r <= '0;
      txShift_r <= '0;
      txBits_r <= '0;
    end else begin
      case (txState_r)
        TX_IDLE: begin
          txCnt_r <= '0;
          if (cmdParityMid) begin
            txState_r <= TX_WAIT;
          end
        end
        // R7 response delay
        TX_WAIT: begin
          txCnt_r <= txCnt_r + 1'b1;
          if (txStart) begin
            txFrame_r <= {SYNC_PATTERN, statusWord, ~^statusWord};
            txShift_r <= {SYNC_PATTERN, statusWord, ~^statusWord};
            txBits_r <= '0;
            txCnt_r <= '0;
            txState_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          txCnt_r <= bitTick ? '0 : txCnt_r + 1'b1;
          if (bitTick) begin
            txShift_r <= {txShift_r[FRAME_BITS-2:0], 1'b0};
            txBits_r <= txBits_r + 1'b1;
            if (txBits_r == 8'(FRAME_BITS - 1)) begin
              txState_r <= TX_IDLE;
            end
          end
        end
        default: begin
          txState_r <= TX_IDLE;
        end
      endcase
    end
  end

  assign link.busATransmitOut = (txState_r == TX_SHIFT) && txShift_r[FRAME_BITS-1];

  // echo decoder and checker
  ebrrt_ec_e ecState_r;
  logic [CNT_W-1:0] ecCnt_r;
  logic [7:0] ecBits_r;
  logic [FRAME_BITS-1:0] ecShift_r;
  logic rxPrev_r;
  logic ecDone_r;
  logic ecBad;
  logic echoErr_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ecState_r <= EC_IDLE;
      ecCnt_r <= '0;
      ecBits_r <= '0;
      ecShift_r <= '0;
      rxPrev_r <= 1'b0;
      ecDone_r <= 1'b0;
      ecBad <= 1'b0;
    end else begin
      rxPrev_r <= rxLvl_r;
      ecDone_r <= 1'b0;
      ecBad <= 1'b0;
      case (ecState_r)
        EC_IDLE: begin
          if (txStart) begin
            ecCnt_r <= '0;
            ecState_r <= EC_FIND;
          end
        end
        // R10 echo must start in window
        EC_FIND: begin
          ecCnt_r <= ecCnt_r + 1'b1;
          if (rxLvl_r && !rxPrev_r) begin
            ecCnt_r <= CNT_W'(BIT_CYC / 2);
            ecBits_r <= '0;
            ecState_r <= EC_BITS;
          end else if (ecCnt_r == CNT_W'(ECHO_WIN)) begin
            ecBad <= 1'b1;
            ecDone_r <= 1'b1;
            ecState_r <= EC_IDLE;
          end
        end
        // R9 sample mid-bit, compare word
        EC_BITS: begin
          ecCnt_r <= ecCnt_r - 1'b1;
          if (ecCnt_r == '0) begin
            ecCnt_r <= CNT_W'(BIT_CYC - 1);
            ecShift_r <= {ecShift_r[FRAME_BITS-2:0], rxLvl_r};
            ecBits_r <= ecBits_r + 1'b1;
            if (ecBits_r == 8'(FRAME_BITS - 1)) begin
              ecBad <= ({ecShift_r[FRAME_BITS-2:0], rxLvl_r} != txFrame_r);
              ecDone_r <= 1'b1;
              ecState_r <= EC_IDLE;
            end
          end
        end
        default: begin
          ecState_r <= EC_IDLE;
        end
      endcase
    end
  end

  // R11 sticky error, set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      echoErr_r <= 1'b0;
    end else if (ecBad) begin
      echoErr_r <= 1'b1;
    end else if (errorClearInput) begin
      echoErr_r <= 1'b0;
    end
  end

  assign echoCheckDone = ecDone_r;
  assign busAEchoError = echoErr_r;
endmodule : ebrrt_device

// File: hw/ebrrt_partner.sv
`timescale 1ns/1ps
module ebrrt_partner #(
  parameter int MEM_DEPTH = 256,
  parameter int GRANT_LAT = 4,
  parameter int WAIT_STATES = 0,
  parameter int LEGAL_LAT = 10,
  parameter int ECHO_DELAY = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  ebrrt_link_if.host link,
  input wire logic memWrEn,
  input wire logic [ebrrt_pkg::ADDR_W-1:0] memWrAddr,
  input wire logic [ebrrt_pkg::DATA_W-1:0] memWrData,
  input wire logic [(1 << ebrrt_pkg::SA_W)-1:0] legalMask,
  input wire logic echoCorrupt
);
  import ebrrt_pkg::*;

  if (GRANT_LAT < 0 || GRANT_LAT >= GRANT_CYC) begin : g_chk_grant
    $error("grant latency out of range");
  end
  if (LEGAL_LAT < 1 || LEGAL_LAT >= LEGAL_CYC) begin : g_chk_legal
    $error("legality latency out of range");
  end
  if (ECHO_DELAY < 1 || ECHO_DELAY > ECHO_CYC) begin : g_chk_echo
    $error("echo delay out of range");
  end
  if (MEM_DEPTH < 2 || MEM_DEPTH > (1 << ADDR_W) || WAIT_STATES < 0 || WAIT_STATES > 255) begin : g_chk_mem
    $error("memory depth or wait states out of range");
  end

  localparam int MA_W = $clog2(MEM_DEPTH);

  // R4 grant after fixed latency
  logic [CNT_W-1:0] grCnt_r;
  logic grant_r;

  always_ff @(posedge clk_sys) begin
    if (rst || link.backendRequestN) begin
      grCnt_r <= '0;
      grant_r <= 1'b0;
    end else if (grCnt_r == CNT_W'(GRANT_LAT)) begin
      grant_r <= 1'b1;
    end else begin
      grCnt_r <= grCnt_r + 1'b1;
    end
  end

  assign link.backendGrantN = !grant_r;

  // R3 memory data ahead of strobe
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] rdData_r;

  always_ff @(posedge clk_sys) begin
    if (memWrEn) begin
      mem[memWrAddr[MA_W-1:0]] <= memWrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_r <= DATA_RST;
    end else begin
      rdData_r <= mem[link.backendAddr[MA_W-1:0]];
    end
  end

  assign link.backendData = rdData_r;

  // R13 wait for set number of cycles
  logic [7:0] lowCnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst || link.backendReadStrobeN) begin
      lowCnt_r <= '0;
    end else if (lowCnt_r != 8'hff) begin
      lowCnt_r <= lowCnt_r + 1'b1;
    end
  end

  assign link.backendWait = !link.backendReadStrobeN && (lowCnt_r < 8'(WAIT_STATES));

  // R5 decode within latency
  // R6 flag only when legal
  logic [CMD_W-1:0] valPrev_r;
  logic [CNT_W-1:0] legCnt_r;
  logic legFlag_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valPrev_r <= CMD_RST;
      legCnt_r <= '0;
      legFlag_r <= 1'b0;
    end else begin
      valPrev_r <= link.decodedCommandValue;
      if (link.decodedCommandValue != valPrev_r) begin
        legCnt_r <= CNT_W'(LEGAL_LAT - 1);
        legFlag_r <= 1'b0;
      end else if (legCnt_r != '0) begin
        legCnt_r <= legCnt_r - 1'b1;
      end else begin
        legFlag_r <= legalMask[link.decodedCommandValue[SA_LSB +: SA_W]];
      end
    end
  end

  assign link.commandLegalFlag = legFlag_r;

  // R10 echo delay line
  logic [ECHO_DELAY-1:0] echo_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      echo_r <= '0;
    end else begin
      echo_r <= ECHO_DELAY'({echo_r, link.busATransmitOut});
    end
  end

  assign link.busAReceiveIn = echo_r[ECHO_DELAY-1] ^ (echoCorrupt & link.busATransmitOut);
endmodule : ebrrt_partner

// File: tb/ebrrt_link_monitor.sv
`timescale 1ns/1ps
module ebrrt_link_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic backendRequestN,
  input wire logic backendGrantN,
  input wire logic backendReadStrobeN,
  input wire logic [ebrrt_pkg::ADDR_W-1:0] backendAddr,
  input wire logic backendWait,
  input wire logic [ebrrt_pkg::CMD_W-1:0] decodedCommandValue,
  input wire logic commandLegalFlag,
  input wire logic busATransmitOut
);
  import ebrrt_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  strobe_one_cycle_a:
    assert property ($fell(backendReadStrobeN) && !backendWait |=> backendReadStrobeN)
    else $error("read strobe low past one cycle without wait");
  wait_extends_a:
    assert property (!backendReadStrobeN && backendWait |=> !backendReadStrobeN)
    else $error("read strobe ended while wait sampled high");
  addr_setup_a:
    assert property ($fell(backendReadStrobeN) |-> $stable(backendAddr) && !$past(backendRequestN))
    else $error("address not settled before read strobe");
  addr_hold_a:
    assert property ($rose(backendReadStrobeN) |-> $stable(backendAddr) ##1 $stable(backendAddr))
    else $error("address moved after read strobe");
  request_release_a:
    assert property ($rose(backendReadStrobeN) |-> !backendRequestN ##1 backendRequestN)
    else $error("request not released one cycle after strobe");
  grant_deadline_a:
    assert property ($fell(backendRequestN) |-> ##[0:60] !backendGrantN)
    else $error("grant later than 60 cycles");
  bit_length_a:
    assert property ($rose(busATransmitOut) |-> busATransmitOut [*5])
    else $error("transmit high shorter than one bit");
  bit_low_a:
    assert property ($fell(busATransmitOut) |-> !busATransmitOut [*5])
    else $error("transmit low shorter than one bit");
  legal_drop_a:
    assert property ($changed(decodedCommandValue) |-> ##[0:1] !commandLegalFlag)
    else $error("legal flag kept across command change");
endmodule : ebrrt_link_monitor

// File: tb/ebrrt_tb.sv
`timescale 1ns/1ps
module ebrrt_tb;
  import ebrrt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic readReq = 1'b0;
  logic [ADDR_W-1:0] readAddr = 16'h0000;
  logic readBusy, readDone, readFail;
  logic [DATA_W-1:0] readData;
  logic cmdParityMid = 1'b0, rtRtReceive = 1'b0, firstDataSync = 1'b0, errorClearInput = 1'b0;
  logic [CMD_W-1:0] cmdValue = 12'h000;
  logic [RTADDR_W-1:0] rtAddr = 5'h05;
  logic cmdCheckDone, cmdLegal, rtRtActive, rtRtTimeout, echoCheckDone, busAEchoError;
  logic memWrEn = 1'b0, echoCorrupt = 1'b0;
  logic [ADDR_W-1:0] memWrAddr = 16'h0000;
  logic [DATA_W-1:0] memWrData = 16'h0000;
  logic [31:0] legalMask = 32'h0000_0004;
  int badCount = 0;
  int comparisons = 0;
  int n;

  always #10 clk_sys = ~clk_sys;

  ebrrt_link_if link ();
  ebrrt_device ebrrt_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .readReq(readReq),
    .readAddr(readAddr), .readBusy(readBusy), .readDone(readDone), .readFail(readFail), .readData(readData),
    .cmdParityMid(cmdParityMid), .cmdValue(cmdValue), .rtRtReceive(rtRtReceive), .firstDataSync(firstDataSync),
    .rtAddr(rtAddr), .cmdCheckDone(cmdCheckDone), .cmdLegal(cmdLegal), .rtRtActive(rtRtActive),
    .rtRtTimeout(rtRtTimeout), .echoCheckDone(echoCheckDone), .busAEchoError(busAEchoError),
    .errorClearInput(errorClearInput));
  ebrrt_partner ebrrt_partner_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .legalMask(legalMask), .echoCorrupt(echoCorrupt));
  ebrrt_link_monitor ebrrt_link_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .backendRequestN(link.backendRequestN), .backendGrantN(link.backendGrantN),
    .backendReadStrobeN(link.backendReadStrobeN), .backendAddr(link.backendAddr),
    .backendWait(link.backendWait), .decodedCommandValue(link.decodedCommandValue),
    .commandLegalFlag(link.commandLegalFlag), .busATransmitOut(link.busATransmitOut));

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tallyAndFinish

  function automatic logic sel(input int w);
    case (w)
      0: return readDone;
      1: return cmdCheckDone;
      2: return link.busATransmitOut;
      3: return echoCheckDone;
      default: return rtRtTimeout;
    endcase
  endfunction : sel

  // bounded wait for one of the completion signals or the transmit output
  task automatic waitSig(input int w, input int bound, output int cnt);
    cnt = 0;
    while (sel(w) !== 1'b1) begin
      if (cnt >= bound) begin
        badCount++;
        $display("CHECK FAILED wait %0d expected 1 seen timeout", w);
        tallyAndFinish();
      end
      tick(1);
      cnt++;
    end
  endtask : waitSig

  task automatic sendCmd(input logic [CMD_W-1:0] v, input logic rr);
    cmdValue = v;
    rtRtReceive = rr;
    cmdParityMid = 1'b1;
    tick(1);
    cmdParityMid = 1'b0;
  endtask : sendCmd

  task automatic doRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    readAddr = a;
    readReq = 1'b1;
    tick(1);
    readReq = 1'b0;
    chk("read busy", 32'h1, {31'h0, readBusy});
    waitSig(0, 100, n);
    chk("read data", {16'h0000, exp}, {16'h0000, readData});
    chk("read fail", 32'h0000_0000, {31'h0000_0000, readFail});
  endtask : doRead

  task automatic testRead();
    memWrEn = 1'b1;
    memWrAddr = 16'h0012;
    memWrData = 16'hA5C3;
    tick(1);
    memWrAddr = 16'h0013;
    memWrData = 16'h3C5A;
    tick(1);
    memWrEn = 1'b0;
    doRead(16'h0012, 16'hA5C3);
    doRead(16'h0013, 16'h3C5A);
    $display("test read ended");
  endtask : testRead

  task automatic testLegal();
    sendCmd(12'hC45, 1'b0);
    waitSig(1, 160, n);
    chk("legal result", 32'h1, {31'h0, cmdLegal});
    chk("legal in time", 32'h1, {31'h0, n <= LEGAL_CYC});
    tick(200);
    sendCmd(12'h065, 1'b0);
    waitSig(1, 160, n);
    chk("illegal result", 32'h0, {31'h0, cmdLegal});
    tick(200);
    $display("test legality ended");
  endtask : testLegal

  task automatic testEcho();
    sendCmd(12'h045, 1'b0);
    waitSig(2, 60, n);
    chk("response window", 32'h1, {31'h0, n >= 13 && n <= 32});
    waitSig(3, 200, n);
    tick(1);
    chk("echo clean", 32'h0, {31'h0, busAEchoError});
    tick(50);
    echoCorrupt = 1'b1;
    sendCmd(12'h045, 1'b0);
    waitSig(3, 250, n);
    tick(1);
    chk("echo error set", 32'h1, {31'h0, busAEchoError});
    echoCorrupt = 1'b0;
    tick(50);
    sendCmd(12'h045, 1'b0);
    waitSig(3, 250, n);
    tick(2);
    chk("echo error sticky", 32'h1, {31'h0, busAEchoError});
    errorClearInput = 1'b1;
    tick(1);
    errorClearInput = 1'b0;
    tick(1);
    chk("echo error cleared", 32'h0, {31'h0, busAEchoError});
    tick(50);
    $display("test echo ended");
  endtask : testEcho

  task automatic testRtRt();
    sendCmd(12'h045, 1'b1);
    waitSig(4, 3700, n);
    chk("rt-rt timeout", 32'h1, {31'h0, n >= RTRT_CYC - 2 && n <= RTRT_CYC + 1});
    tick(200);
    sendCmd(12'h045, 1'b1);
    tick(100);
    firstDataSync = 1'b1;
    tick(1);
    firstDataSync = 1'b0;
    tick(2);
    chk("rt-rt stopped", 32'h0, {31'h0, rtRtActive});
    n = 0;
    repeat (3600) begin
      tick(1);
      if (rtRtTimeout !== 1'b0) begin
        n++;
      end
    end
    chk("rt-rt no timeout", 32'h0, n);
    $display("test rt-rt ended");
  endtask : testRtRt

  initial begin
    tick(6);
    rst = 1'b0;
    tick(4);
    testRead();
    testLegal();
    testEcho();
    testRtRt();
    tallyAndFinish();
  end
endmodule : ebrrt_tb
